// File: rcw_pkg.sv
// Package: register map, field layout, timing constants and types
package rcw_pkg;
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_WAKE_TIMING = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_SLEEP_TIME = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_SLEEP_CTRL = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_ELAPSED = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_EXCH_BASE = 8'h14;

	localparam int CTRL_ENTRY_BIT = 0;
	localparam int CTRL_EXT_DIS_BIT = 1;
	localparam int CTRL_WAKE_REQ_BIT = 2;
	localparam int ST_PD_ALLOWED_BIT = 0;
	localparam int ST_ASLEEP_BIT = 1;
	localparam int ST_LP_IRQ_BIT = 2;
	localparam int ST_EXIT_IRQ_BIT = 3;
	localparam int ST_LP_TIMEBASE_BIT = 4;

	localparam logic [31:0] WAKE_TIMING_RST = 32'h0002_0104;
	localparam logic [31:0] SLEEP_TIME_RST = 32'h0000_0000;
	localparam logic [15:0] EXCH_BASE_RST = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Core clock and slot reference timing
	localparam int CLK_FREQ_HZ = 20000000;
	localparam int CLK_PERIOD_NS = 50;
	localparam int SLOT_TIME_NS = 625000;
	localparam int SLOT_CLK_CYCLES = SLOT_TIME_NS / CLK_PERIOD_NS;
	localparam int LP_FREQ_HZ = 32000;
	localparam int SLOT_LP_TICKS = (SLOT_TIME_NS / 1000) * LP_FREQ_HZ
		/ 1000000;
	// Core operating clock choices
	localparam int CORE_CLK_FAST_HZ = 16000000;
	localparam int CORE_CLK_SLOW_HZ = 8000000;
	localparam int EXCH_RANGE_BYTES = 65536;

	typedef struct packed {
		logic [7:0] unused;
		logic [7:0] extPulseLen;
		logic [7:0] leadClear;
		logic [7:0] leadSet;
	} rcw_timing_t;

	typedef enum logic [4:0] {
		ST_ACTIVE = 5'b00001,
		ST_ENTER = 5'b00010,
		ST_SLEEP = 5'b00100,
		ST_EXT = 5'b01000,
		ST_WAIT_UP = 5'b10000
	} rcw_state_t;
endpackage

// File: rcw_lp_tick.sv
// Edge detector turning the sampled low-power clock into core-clock ticks
`timescale 1ns/1ps
module rcw_lp_tick (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic lpClk,
	output logic tick
);
	logic prev_r;
	logic prev_nxt;
	logic tick_r;
	logic tick_nxt;

	always_comb begin
		prev_nxt = lpClk;
		tick_nxt = lpClk & ~prev_r;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_r <= 1'b0;
			tick_r <= 1'b0;
		end else begin
			prev_r <= prev_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick = tick_r;
endmodule

// File: rcw_deep_sleep.sv
// Deep-sleep entry and wake-up controller with AXI4-Lite register slave
`timescale 1ns/1ps

// Overview of operation
// - Wake irq always precedes sleep-exit irq
// - Wake irq rises irq_lead_set ticks before expiry
// - Elapsed status shows true sleep length
// - Wake irq falls irq_lead_clear ticks before end
// - External wake irq high ext_pulse minus lead_clear
// - Wake request raises wake irq immediately
// - Timebase moves to low-power clock in sleep
// - Power-down allowed flag marks transition done
// - Sleep ends by timer or wake request
// - Timed wake irq leads scheduled instant
// - Exchange memory base, 64 kB range
// - Core clock 16/8 MHz, sleep clock low; slot reference here assumes a 20 MHz (50 ns) core clock
// - Expired timer waits for core power up
// - Powered, clocked, expired core asserts exit irq
// - No sleep entry while wake request high
// - Ext-wake disable blocks wake request
module rcw_deep_sleep
	import rcw_pkg::*;
#(
	parameter int SLOT_CLK = SLOT_CLK_CYCLES,
	parameter int SLOT_LP = SLOT_LP_TICKS
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic lowPowerClock,
	input wire logic coreClocksEnabled,
	input wire logic corePowered,
	output logic lpWakeupIrq,
	output logic sleepExitIrq,
	output logic powerdownAllowedFlag,
	output logic lpTimebase,
	output logic slotTick,
	output logic [15:0] exchangeMemBase
);
	logic lpTick;
	rcw_state_t state_r, state_nxt;
	rcw_timing_t timing_r, timing_nxt;
	logic [31:0] duration_r, duration_nxt;
	logic [31:0] elapsed_r, elapsed_nxt;
	logic [7:0] extCnt_r, extCnt_nxt;
	logic entry_r, entry_nxt;
	logic extDis_r, extDis_nxt;
	logic wakeReq_r, wakeReq_nxt;
	logic lpIrq_r, lpIrq_nxt;
	logic irqRaised_r, irqRaised_nxt;
	logic irqDone_r, irqDone_nxt;
	logic exitIrq_r, exitIrq_nxt;
	logic pdAllowed_r, pdAllowed_nxt;
	logic lpBase_r, lpBase_nxt;
	logic [15:0] emBase_r, emBase_nxt;
	logic [13:0] slotCnt_r, slotCnt_nxt;
	logic slot_r, slot_nxt;
	logic awHeld_r, awHeld_nxt;
	logic wHeld_r, wHeld_nxt;
	logic [ADDR_W-1:0] awAddr_r, awAddr_nxt;
	logic [31:0] wData_r, wData_nxt;
	logic [3:0] wStrb_r, wStrb_nxt;
	logic bValid_r, bValid_nxt;
	logic [1:0] bResp_r, bResp_nxt;
	logic arReady_r, arReady_nxt;
	logic rValid_r, rValid_nxt;
	logic [31:0] rData_r, rData_nxt;
	logic [1:0] rResp_r, rResp_nxt;
	logic doWrite;
	logic [32:0] elapsedNext;
	logic [32:0] setPoint;
	logic [32:0] clearPoint;
	logic [8:0] extPoint;
	logic [31:0] baseWord;

	rcw_lp_tick u_tick (
		.clk(clk),
		.rst_n(rst_n),
		.lpClk(lowPowerClock),
		.tick(lpTick)
	);

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// Bus slave: address and data may arrive in either order
	always_comb begin
		awHeld_nxt = awHeld_r;
		wHeld_nxt = wHeld_r;
		awAddr_nxt = awAddr_r;
		wData_nxt = wData_r;
		wStrb_nxt = wStrb_r;
		bValid_nxt = bValid_r;
		bResp_nxt = bResp_r;
		doWrite = 1'b0;
		if (s_axi_awvalid && !awHeld_r) begin
			awHeld_nxt = 1'b1;
			awAddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && !wHeld_r) begin
			wHeld_nxt = 1'b1;
			wData_nxt = s_axi_wdata;
			wStrb_nxt = s_axi_wstrb;
		end
		if (bValid_r && s_axi_bready) begin
			bValid_nxt = 1'b0;
		end
		if (awHeld_r && wHeld_r && !bValid_r) begin
			doWrite = 1'b1;
			awHeld_nxt = 1'b0;
			wHeld_nxt = 1'b0;
			bValid_nxt = 1'b1;
			case (awAddr_r[ADDR_W-1:2])
				OFF_WAKE_TIMING[ADDR_W-1:2], OFF_SLEEP_TIME[ADDR_W-1:2],
				OFF_SLEEP_CTRL[ADDR_W-1:2], OFF_ELAPSED[ADDR_W-1:2],
				OFF_STATUS[ADDR_W-1:2], OFF_EXCH_BASE[ADDR_W-1:2]:
					bResp_nxt = RESP_OKAY;
				default: bResp_nxt = RESP_SLVERR;
			endcase
		end
	end

	always_comb begin
		arReady_nxt = 1'b0;
		rValid_nxt = rValid_r;
		rData_nxt = rData_r;
		rResp_nxt = rResp_r;
		if (rValid_r && s_axi_rready) begin
			rValid_nxt = 1'b0;
		end
		if (s_axi_arvalid && !arReady_r && !rValid_r) begin
			arReady_nxt = 1'b1;
			rValid_nxt = 1'b1;
			rResp_nxt = RESP_OKAY;
			case (s_axi_araddr[ADDR_W-1:2])
				OFF_WAKE_TIMING[ADDR_W-1:2]: rData_nxt = timing_r;
				OFF_SLEEP_TIME[ADDR_W-1:2]: rData_nxt = duration_r;
				OFF_SLEEP_CTRL[ADDR_W-1:2]:
					rData_nxt = {29'd0, wakeReq_r, extDis_r, entry_r};
				OFF_ELAPSED[ADDR_W-1:2]: rData_nxt = elapsed_r;
				OFF_STATUS[ADDR_W-1:2]:
					rData_nxt = {27'd0, lpBase_r, exitIrq_r, lpIrq_r,
						(state_r != ST_ACTIVE), pdAllowed_r};
				OFF_EXCH_BASE[ADDR_W-1:2]: rData_nxt = {emBase_r, 16'h0000};
				default: begin
					rData_nxt = 32'h0000_0000;
					rResp_nxt = RESP_SLVERR;
				end
			endcase
		end
	end

	// Sleep sequencer
	always_comb begin
		state_nxt = state_r;
		timing_nxt = timing_r;
		duration_nxt = duration_r;
		elapsed_nxt = elapsed_r;
		extCnt_nxt = extCnt_r;
		entry_nxt = entry_r;
		extDis_nxt = extDis_r;
		wakeReq_nxt = wakeReq_r;
		lpIrq_nxt = lpIrq_r;
		irqRaised_nxt = irqRaised_r;
		irqDone_nxt = irqDone_r;
		exitIrq_nxt = exitIrq_r;
		pdAllowed_nxt = pdAllowed_r;
		lpBase_nxt = lpBase_r;
		emBase_nxt = emBase_r;
		baseWord = merge({emBase_r, 16'h0000}, wData_r, wStrb_r);
		elapsedNext = {1'b0, elapsed_r} + 33'd1;
		// Wake edges: elapsed + lead reaches duration
		setPoint = elapsedNext + {25'd0, timing_r.leadSet};
		clearPoint = elapsedNext + {25'd0, timing_r.leadClear};
		extPoint = {1'b0, extCnt_r} + 9'd1 + {1'b0, timing_r.leadClear};
		if (doWrite) begin
			case (awAddr_r[ADDR_W-1:2])
				OFF_WAKE_TIMING[ADDR_W-1:2]:
					timing_nxt = merge(timing_r, wData_r, wStrb_r);
				OFF_SLEEP_TIME[ADDR_W-1:2]:
					duration_nxt = merge(duration_r, wData_r, wStrb_r);
				OFF_SLEEP_CTRL[ADDR_W-1:2]: if (wStrb_r[0]) begin
					entry_nxt = wData_r[CTRL_ENTRY_BIT];
					extDis_nxt = wData_r[CTRL_EXT_DIS_BIT];
					wakeReq_nxt = wData_r[CTRL_WAKE_REQ_BIT];
				end
				OFF_STATUS[ADDR_W-1:2]:
					if (wStrb_r[0] && wData_r[ST_EXIT_IRQ_BIT]) begin
						exitIrq_nxt = 1'b0;
					end
				OFF_EXCH_BASE[ADDR_W-1:2]:
					emBase_nxt = baseWord[31:16];
				default: ;
			endcase
		end
		case (state_r)
			ST_ACTIVE: begin
				if (entry_r && !wakeReq_r) begin
					state_nxt = ST_ENTER;
					elapsed_nxt = 32'h0000_0000;
					irqRaised_nxt = 1'b0;
					irqDone_nxt = 1'b0;
				end
			end
			ST_ENTER: begin
				if (wakeReq_r && !extDis_r) begin
					state_nxt = ST_EXT;
					lpIrq_nxt = 1'b1;
					extCnt_nxt = 8'h00;
				end else if (lpTick) begin
					// Timebase handed to the low-power clock
					state_nxt = ST_SLEEP;
					lpBase_nxt = 1'b1;
					pdAllowed_nxt = 1'b1;
				end
			end
			ST_SLEEP: begin
				if (wakeReq_r && !extDis_r && !irqRaised_r) begin
					state_nxt = ST_EXT;
					lpIrq_nxt = 1'b1;
					irqRaised_nxt = 1'b1;
					extCnt_nxt = 8'h00;
				end else if (lpTick) begin
					elapsed_nxt = elapsedNext[31:0];
					if (!irqRaised_r && setPoint >= {1'b0, duration_r}) begin
						lpIrq_nxt = 1'b1;
						irqRaised_nxt = 1'b1;
					end else if (irqRaised_r && !irqDone_r &&
						clearPoint >= {1'b0, duration_r}) begin
						lpIrq_nxt = 1'b0;
						irqDone_nxt = 1'b1;
					end
					// Expiry waits until the wake pulse has run
					if (irqDone_r && elapsedNext >= {1'b0, duration_r}) begin
						state_nxt = ST_WAIT_UP;
					end
				end
			end
			ST_EXT: begin
				if (lpTick) begin
					elapsed_nxt = elapsedNext[31:0];
					extCnt_nxt = extCnt_r + 8'd1;
					// Held until extPulseLen minus leadClear ticks
					if (extPoint >= {1'b0, timing_r.extPulseLen}) begin
						lpIrq_nxt = 1'b0;
						irqDone_nxt = 1'b1;
						state_nxt = ST_WAIT_UP;
					end
				end
			end
			ST_WAIT_UP: begin
				// Elapsed keeps growing until the core is back
				if (lpTick) begin
					elapsed_nxt = elapsedNext[31:0];
				end
				if (corePowered && coreClocksEnabled) begin
					state_nxt = ST_ACTIVE;
					exitIrq_nxt = 1'b1;
					entry_nxt = 1'b0;
					pdAllowed_nxt = 1'b0;
					lpBase_nxt = 1'b0;
				end
			end
			default: state_nxt = ST_ACTIVE;
		endcase
	end

	// Slot reference: core cycles when active, lp ticks when asleep
	always_comb begin
		slotCnt_nxt = slotCnt_r;
		slot_nxt = 1'b0;
		if (!lpBase_r || lpTick) begin
			if ({18'd0, slotCnt_r} >= (lpBase_r ? SLOT_LP : SLOT_CLK) - 1)
			begin
				slotCnt_nxt = 14'd0;
				slot_nxt = 1'b1;
			end else begin
				slotCnt_nxt = slotCnt_r + 14'd1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			awAddr_r <= '0;
			wData_r <= 32'h0000_0000;
			wStrb_r <= 4'h0;
			bValid_r <= 1'b0;
			bResp_r <= RESP_OKAY;
			arReady_r <= 1'b0;
			rValid_r <= 1'b0;
			rData_r <= 32'h0000_0000;
			rResp_r <= RESP_OKAY;
		end else begin
			awHeld_r <= awHeld_nxt;
			wHeld_r <= wHeld_nxt;
			awAddr_r <= awAddr_nxt;
			wData_r <= wData_nxt;
			wStrb_r <= wStrb_nxt;
			bValid_r <= bValid_nxt;
			bResp_r <= bResp_nxt;
			arReady_r <= arReady_nxt;
			rValid_r <= rValid_nxt;
			rData_r <= rData_nxt;
			rResp_r <= rResp_nxt;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_ACTIVE;
			timing_r <= WAKE_TIMING_RST;
			duration_r <= SLEEP_TIME_RST;
			elapsed_r <= 32'h0000_0000;
			extCnt_r <= 8'h00;
			entry_r <= 1'b0;
			extDis_r <= 1'b0;
			wakeReq_r <= 1'b0;
			lpIrq_r <= 1'b0;
			irqRaised_r <= 1'b0;
			irqDone_r <= 1'b0;
			exitIrq_r <= 1'b0;
			pdAllowed_r <= 1'b0;
			lpBase_r <= 1'b0;
			emBase_r <= EXCH_BASE_RST;
			slotCnt_r <= 14'd0;
			slot_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			timing_r <= timing_nxt;
			duration_r <= duration_nxt;
			elapsed_r <= elapsed_nxt;
			extCnt_r <= extCnt_nxt;
			entry_r <= entry_nxt;
			extDis_r <= extDis_nxt;
			wakeReq_r <= wakeReq_nxt;
			lpIrq_r <= lpIrq_nxt;
			irqRaised_r <= irqRaised_nxt;
			irqDone_r <= irqDone_nxt;
			exitIrq_r <= exitIrq_nxt;
			pdAllowed_r <= pdAllowed_nxt;
			lpBase_r <= lpBase_nxt;
			emBase_r <= emBase_nxt;
			slotCnt_r <= slotCnt_nxt;
			slot_r <= slot_nxt;
		end
	end

	assign s_axi_awready = ~awHeld_r;
	assign s_axi_wready = ~wHeld_r;
	assign s_axi_bvalid = bValid_r;
	assign s_axi_bresp = bResp_r;
	assign s_axi_arready = arReady_r;
	assign s_axi_rvalid = rValid_r;
	assign s_axi_rdata = rData_r;
	assign s_axi_rresp = rResp_r;
	assign lpWakeupIrq = lpIrq_r;
	assign sleepExitIrq = exitIrq_r;
	assign powerdownAllowedFlag = pdAllowed_r;
	assign lpTimebase = lpBase_r;
	assign slotTick = slot_r;
	assign exchangeMemBase = emBase_r;
endmodule

// File: rcw_pm_model.sv
// Power-management and clock-gating model on the far side of the block
`timescale 1ns/1ps
module rcw_pm_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic powerdownAllowedFlag,
	input wire logic lpWakeupIrq,
	input wire logic slowUp,
	output logic lowPowerClock,
	output logic coreClocksEnabled,
	output logic corePowered
);
	logic waking;
	logic lpClk_r = 1'b0;
	int upCnt;
	// Sleep clock runs free, period 400 ns (8 clk cycles), edges on clk falling edges
	always #200 lpClk_r = ~lpClk_r;
	assign lowPowerClock = lpClk_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			coreClocksEnabled <= 1'b1;
			corePowered <= 1'b1;
			waking <= 1'b0;
			upCnt <= 0;
		end else if (lpWakeupIrq || waking) begin
			// Slow mode lets the timer expire long before power returns
			waking <= powerdownAllowedFlag || lpWakeupIrq;
			upCnt <= upCnt + 1;
			if (upCnt >= (slowUp ? 200 : 4)) begin
				corePowered <= 1'b1;
				coreClocksEnabled <= corePowered;
			end
		end else if (powerdownAllowedFlag) begin
			coreClocksEnabled <= 1'b0;
			corePowered <= coreClocksEnabled ? corePowered : 1'b0;
			upCnt <= 0;
		end
	end
endmodule

// File: rcw_deep_sleep_sva.sv
// Concurrent checks on the deep-sleep controller ports
`timescale 1ns/1ps
module rcw_deep_sleep_sva (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic coreClocksEnabled,
	input wire logic corePowered,
	input wire logic lpWakeupIrq,
	input wire logic sleepExitIrq,
	input wire logic powerdownAllowedFlag,
	input wire logic lpTimebase
);
	logic sawWake_r;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sawWake_r <= 1'b0;
		end else if (lpWakeupIrq) begin
			sawWake_r <= 1'b1;
		end else if (sleepExitIrq) begin
			sawWake_r <= 1'b0;
		end
	end
	sequence s_exitRise; $rose(sleepExitIrq); endsequence
	sequence s_wrHeld;
		!s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	endsequence
	property p_exitAfterWake; s_exitRise |-> sawWake_r; endproperty
	a_exitAfterWake: assert property (p_exitAfterWake) else
		$error("exit irq before wake irq");
	property p_exitPower;
		s_exitRise |-> $past(corePowered) && $past(coreClocksEnabled);
	endproperty
	a_exitPower: assert property (p_exitPower) else
		$error("exit irq while core down");
	property p_exitEnds;
		s_exitRise |-> !powerdownAllowedFlag && !lpTimebase;
	endproperty
	a_exitEnds: assert property (p_exitEnds) else
		$error("sleep flags left set at exit");
	property p_timebase; powerdownAllowedFlag |-> lpTimebase; endproperty
	a_timebase: assert property (p_timebase) else
		$error("sleep without low-power timebase");
	property p_wrAnswer; s_wrHeld |=> s_axi_bvalid; endproperty
	a_wrAnswer: assert property (p_wrAnswer) else
		$error("write response late");
	property p_bClear;
		s_axi_bvalid && s_axi_bready |=>
			!s_axi_bvalid && s_axi_awready && s_axi_wready;
	endproperty
	a_bClear: assert property (p_bClear) else
		$error("write channel not freed");
	property p_rdAnswer;
		s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=>
			s_axi_arready && s_axi_rvalid;
	endproperty
	a_rdAnswer: assert property (p_rdAnswer) else
		$error("read response late");
	property p_arPulse; s_axi_arready |=> !s_axi_arready; endproperty
	a_arPulse: assert property (p_arPulse) else
		$error("arready longer than one cycle");
endmodule
bind rcw_deep_sleep rcw_deep_sleep_sva i_rcw_deep_sleep_sva (.clk, .rst_n,
	.s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .coreClocksEnabled,
	.corePowered, .lpWakeupIrq, .sleepExitIrq, .powerdownAllowedFlag,
	.lpTimebase);

// File: rcw_deep_sleep_tb.sv
// Self-checking bench for the deep-sleep wake-up controller
`timescale 1ns/1ps
module rcw_deep_sleep_tb;
	import rcw_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [ADDR_W-1:0] awAddr = '0;
	logic [ADDR_W-1:0] arAddr = '0;
	logic [31:0] wData = '0;
	logic [3:0] wStrb = 4'hF;
	logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
	logic arValid = 1'b0, rReady = 1'b0, slowUp = 1'b0;
	logic awReady, wReady, bValid, arReady, rValid, lpClk, clkEn, pwr;
	logic lpIrq, exitIrq, pdFlag, lpTb, slotTick, lpPrev, pdPrev, irqPrev;
	logic [1:0] bResp, rResp, rs;
	logic [31:0] rData, rd;
	logic [15:0] memBase;
	int n_mismatch = 0, checked = 0;
	int lpEdges = 0, tPd = 0, tRise = 0, tFall = 0, slots = 0, hiCnt = 0;
	logic [ADDR_W-1:0] offs[7] = '{OFF_WAKE_TIMING, OFF_SLEEP_TIME,
		OFF_SLEEP_CTRL, OFF_ELAPSED, OFF_STATUS, OFF_EXCH_BASE, 8'h18};

	always #25 clk = ~clk;
	rcw_deep_sleep #(.SLOT_CLK(8), .SLOT_LP(4)) i_rcw_deep_sleep (.clk(clk),
		.rst_n(rst_n), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
		.s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
		.s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
		.s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
		.s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
		.s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
		.lowPowerClock(lpClk), .coreClocksEnabled(clkEn), .corePowered(pwr),
		.lpWakeupIrq(lpIrq), .sleepExitIrq(exitIrq),
		.powerdownAllowedFlag(pdFlag), .lpTimebase(lpTb), .slotTick(slotTick),
		.exchangeMemBase(memBase));
	rcw_pm_model i_rcw_pm_model (.clk(clk), .rst_n(rst_n),
		.powerdownAllowedFlag(pdFlag), .lpWakeupIrq(lpIrq), .slowUp(slowUp),
		.lowPowerClock(lpClk), .coreClocksEnabled(clkEn), .corePowered(pwr));

	// Timestamps in sleep-clock edges as seen from clk
	always @(posedge clk) begin
		lpPrev <= lpClk;
		pdPrev <= pdFlag;
		irqPrev <= lpIrq;
		if (lpClk && !lpPrev) lpEdges <= lpEdges + 1;
		if (slotTick && pdFlag) slots <= slots + 1;
		if (pdFlag && !pdPrev) tPd <= lpEdges;
		if (lpIrq && !irqPrev) tRise <= lpEdges;
		if (!lpIrq && irqPrev) tFall <= lpEdges;
		if (lpIrq) hiCnt <= irqPrev ? hiCnt + 1 : 1;
	end

	task automatic err(input string msg);
		n_mismatch++;
		$display("[ERR] %0t %s", $time, msg);
	endtask
	task automatic chk_word(input logic [31:0] got, exp, input string what);
		checked++;
		if (got !== exp) err($sformatf("%s got %h exp %h", what, got, exp));
	endtask
	task automatic chk_bit(input logic got, exp, input string what);
		checked++;
		if (got !== exp) err($sformatf("%s got %b", what, got));
	endtask
	task automatic chk_resp(input logic [1:0] got, exp, input string what);
		checked++;
		if (got !== exp) err($sformatf("%s resp %b", what, got));
	endtask
	task automatic finish_test();
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int n;
		@(posedge clk);
		awAddr <= a;
		wData <= d;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (awValid && awReady) awValid <= 1'b0;
			if (wValid && wReady) wValid <= 1'b0;
			if (bValid) break;
		end
		bReady <= 1'b0;
		if (n == 100) begin
			err("write hang");
			finish_test();
		end
		chk_resp(bResp, er, "write");
	endtask
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		@(posedge clk);
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (arValid && arReady) arValid <= 1'b0;
			if (rValid) break;
		end
		rReady <= 1'b0;
		d = rData;
		r = rResp;
		if (n == 100) begin
			err("read hang");
			finish_test();
		end
	endtask
	task automatic wait_pin(input int sel, input logic v, input int lim);
		int n;
		for (n = 0; n < lim; n++) begin
			@(posedge clk);
			if ((sel == 0 ? pdFlag : sel == 1 ? lpIrq : exitIrq) === v) break;
		end
		if (n == lim) begin
			err("wait hang");
			finish_test();
		end
	endtask
	task automatic end_sleep();
		wait_pin(2, 1'b1, 2500);
		axi_read(OFF_STATUS, rd, rs);
		chk_word(rd, 32'h0000_0008, "status exit");
		axi_write(OFF_SLEEP_CTRL, 32'h0000_0000, RESP_OKAY);
		axi_write(OFF_STATUS, 32'h0000_0008, RESP_OKAY);
		chk_bit(exitIrq, 1'b0, "exit irq cleared");
	endtask
	task automatic timed_sleep(input logic slow);
		slowUp <= slow;
		axi_write(OFF_WAKE_TIMING, 32'h0002_0104, RESP_OKAY);
		axi_write(OFF_SLEEP_TIME, 32'h0000_000A, RESP_OKAY);
		axi_write(OFF_SLEEP_CTRL, 32'h0000_0001, RESP_OKAY);
		wait_pin(0, 1'b1, 100);
		chk_bit(lpTb, 1'b1, "timebase");
		axi_read(OFF_STATUS, rd, rs);
		chk_word(rd, 32'h0000_0013, "status asleep");
		wait_pin(1, 1'b1, 400);
		wait_pin(1, 1'b0, 400);
		wait_pin(2, 1'b1, 2500);
		chk_word(tRise - tPd, 6, "irq rise");
		chk_word(tFall - tPd, 9, "irq fall");
		chk_bit(slots > 0, 1'b1, "slot ticks");
		axi_read(OFF_ELAPSED, rd, rs);
		if (slow) chk_bit(rd > 10, 1'b1, "late elapsed");
		else chk_word(rd, 10, "elapsed");
		axi_read(OFF_SLEEP_CTRL, rd, rs);
		chk_bit(rd[CTRL_ENTRY_BIT], 1'b0, "entry cleared");
		end_sleep();
		$display("timed sleep done slow=%0b", slow);
	endtask

	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			axi_read(offs[i], rd, rs);
			chk_word(rd, i == 0 ? WAKE_TIMING_RST : 32'h0000_0000, "reset");
			chk_resp(rs, i == 6 ? RESP_SLVERR : RESP_OKAY, "read");
		end
		axi_write(8'h18, 32'hFFFF_FFFF, RESP_SLVERR);
		axi_write(OFF_EXCH_BASE, 32'hABCD_0000, RESP_OKAY);
		chk_word({16'h0000, memBase}, 32'h0000_ABCD, "base pin");
		axi_read(OFF_EXCH_BASE, rd, rs);
		chk_word(rd, 32'hABCD_0000, "base reg");
		wStrb <= 4'h8;
		axi_write(OFF_EXCH_BASE, 32'h1200_0000, RESP_OKAY);
		wStrb <= 4'hF;
		chk_word({16'h0000, memBase}, 32'h0000_12CD, "base lane");
		$display("register test done");
		timed_sleep(1'b0);
		timed_sleep(1'b1);
		axi_write(OFF_SLEEP_TIME, 32'h0000_0064, RESP_OKAY);
		axi_write(OFF_SLEEP_CTRL, 32'h0000_0001, RESP_OKAY);
		wait_pin(0, 1'b1, 100);
		axi_write(OFF_SLEEP_CTRL, 32'h0000_0005, RESP_OKAY);
		wait_pin(1, 1'b1, 3);
		wait_pin(1, 1'b0, 100);
		chk_bit(hiCnt > 0 && hiCnt <= 10, 1'b1, "ext pulse");
		end_sleep();
		$display("external wake done");
		axi_write(OFF_SLEEP_CTRL, 32'h0000_0005, RESP_OKAY);
		repeat (40) @(posedge clk);
		chk_bit(pdFlag, 1'b0, "entry refused");
		axi_write(OFF_SLEEP_CTRL, 32'h0000_0003, RESP_OKAY);
		wait_pin(0, 1'b1, 100);
		axi_write(OFF_SLEEP_CTRL, 32'h0000_0007, RESP_OKAY);
		repeat (40) @(posedge clk);
		chk_bit(lpIrq, 1'b0, "wake disabled");
		end_sleep();
		$display("refusal test done");
		finish_test();
	end
endmodule
